// *** verilog/tsp_pkg.sv ***
// Package with the sequencer's offsets, field layouts, resets and timing
package tsp_pkg;
   // Clock rate and time figures in their own units
   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned CLK_KHZ       = CLK_MHZ * 1000;
   localparam int unsigned TICK_MS       = 250;
   localparam int unsigned SEC_MS        = 1000;
   localparam int unsigned PW1_US        = 1003;
   localparam int unsigned PW2_US        = 1237;
   localparam int unsigned DEB_MS        = 10;
   // Cycle counts derived from the figures above
   localparam int unsigned TICK_CYC      = TICK_MS * CLK_KHZ;
   localparam int unsigned SEC_CYC       = SEC_MS * CLK_KHZ;
   localparam int unsigned PW1_CYC       = PW1_US * CLK_MHZ;
   localparam int unsigned PW2_CYC       = PW2_US * CLK_MHZ;
   localparam int unsigned DEB_CYC       = DEB_MS * CLK_KHZ;
   // Cycles from pulse timer expiry to the enable falling
   localparam int unsigned SAMPLE_LAT    = 1;
   // Scheduler tick counts
   localparam logic [3:0] TICK_HALF      = 4'h4;
   localparam logic [3:0] TICK_FULL      = 4'h8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_HOLDOFF    = 8'h04;
   localparam logic [7:0] OFS_LEVELS     = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0C;
   localparam logic [7:0] OFS_STAMP      = 8'h10;
   localparam logic [7:0] OFS_SECONDS    = 8'h14;
   // Field positions
   localparam int unsigned CTRL_AUTO_BIT = 0;
   localparam int unsigned LVL_SV_LSB    = 0;
   localparam int unsigned LVL_BK_LSB    = 4;
   localparam int unsigned LVL_MN_LSB    = 8;
   // Reset values
   localparam logic        CTRL_AUTO_RST = 1'b1;
   localparam logic [15:0] HOLDOFF_RST   = 16'h000A;
   localparam logic [2:0]  SV_LVL_RST    = 3'h5;
   localparam logic [2:0]  BK_OK_RST     = 3'h5;
   localparam logic [2:0]  MN_OK_RST     = 3'h6;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_PULSE  = 3'b010,
      ST_SAMPLE = 3'b100
   } tsp_state_e;
endpackage

// *** verilog/tsp_btn_if.sv ***
// Interface carrying the debounced clear press to the sequencer
`timescale 1ns/1ps
interface tsp_btn_if;
   logic press;
   logic level;
   modport src (output press, output level);
   modport dst (input press, input level);
endinterface

// *** verilog/tsp_btn_debounce.sv ***
// Synchroniser and debouncer for the tamper clear push-button
`timescale 1ns/1ps
module tsp_btn_debounce
   import tsp_pkg::*;
#(
   parameter int unsigned DB_CYC = DEB_CYC
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  tamper_clear_button,
   tsp_btn_if.src     btn
);
   logic        sync1_reg, sync2_reg, stab_reg, press_reg;
   logic        stab_next, press_next;
   logic [31:0] cnt_reg, cnt_next;

   if (DB_CYC < 2) begin : g_chk
      $error("Debounce count too small");
   end

   // Restart the count whenever the synced level matches the stable one
   always_comb begin
      stab_next  = stab_reg;
      press_next = 1'b0;
      cnt_next   = 32'h0000_0000;
      if (sync2_reg != stab_reg) begin
         cnt_next = cnt_reg + 32'h0000_0001;
         if (cnt_reg == 32'(DB_CYC - 1)) begin
            stab_next  = sync2_reg;
            press_next = sync2_reg;     // One pulse per press
            cnt_next   = 32'h0000_0000;
         end
      end
   end

   // Two-stage sync; only the second stage is looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         stab_reg  <= 1'b0;
         press_reg <= 1'b0;
         cnt_reg   <= 32'h0000_0000;
      end else begin
         sync1_reg <= tamper_clear_button;
         sync2_reg <= sync1_reg;
         stab_reg  <= stab_next;
         press_reg <= press_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign btn.press = press_reg;
   assign btn.level = stab_reg;
endmodule // tsp_btn_debounce

// *** verilog/tsp_poll_sequencer.sv ***
// Tamper sensor poll sequencer with supply switch control and APB registers
// Functional notes
// - Make a scheduler tick four times per second from the always-on clock.
// - Count ticks; at eight, restart count and advance displayed parameter.
// - At tick count four or eight, raise sensor enable and arm pulse timer.
// - Pulse timer counts once per trigger and gives exactly one end event.
// - Pulse width is picked by a build-time one-coil or two-coil setting.
// - Pulse is 1.003 ms for one coil and 1.237 ms for two coils.
// - Timer terminal count subtracts the sampling latency from pulse width.
// - Detection stays off until a set number of seconds after reset.
// - Sample sensor at pulse end only once the holdoff flag is set.
// - Update indicators, then drop enable; timer idles until next trigger.
// - Capture the seconds timestamp of the first tamper event.
// - Symbols update every sample; LEDs update only on main supply.
// - Refresh the active-supply indicator on every scheduler tick.
// - Auto-switch main and backup; leave second aux off; switch on low.
// - Backup OK threshold resets to level 5, main OK to level 6.
// - Main becoming OK forces a return to main; aux supplies never do.
// - Raise an event whenever the active supply changes either way.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module tsp_poll_sequencer
   import tsp_pkg::*;
#(
   parameter bit          TWO_COIL  = 1'b0,
   parameter int unsigned TICK_CNT  = TICK_CYC,
   parameter int unsigned SEC_CNT   = SEC_CYC,
   parameter int unsigned PW1_CNT   = PW1_CYC,
   parameter int unsigned PW2_CNT   = PW2_CYC,
   parameter int unsigned DB_CNT    = DEB_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tamper_capture_input,
   input  wire logic        tamper_clear_button,
   input  wire logic [2:0]  main_supply,
   input  wire logic [2:0]  backup_supply,
   input  wire logic [2:0]  system_supply,
   output logic             sensor_enable,
   output logic             tamper_symbol,
   output logic             tamper_led,
   output logic             supply_indicator,
   output logic             supply_on_backup,
   output logic             second_aux_supply_enable,
   output logic             supply_switch_event,
   output logic [1:0]       display_param
);
   // Pulse width by board variant, less the sampling latency
   localparam int unsigned PW_CNT = TWO_COIL ? PW2_CNT : PW1_CNT;
   localparam int unsigned PW_TERM = PW_CNT - SAMPLE_LAT;

   if (PW_CNT <= SAMPLE_LAT || PW_CNT >= TICK_CNT || SEC_CNT < 2) begin
      : g_chk
      $error("Timing parameters out of range");
   end

   // Address decode shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // Supply level comparison used for every threshold
   function automatic logic at_least(input logic [2:0] lvl,
                                     input logic [2:0] thr);
      return lvl >= thr;
   endfunction

   tsp_btn_if btn ();

   tsp_btn_debounce #(
      .DB_CYC (DB_CNT)
   ) u_btn (
      .pclk                (pclk),
      .presetn             (presetn),
      .tamper_clear_button (tamper_clear_button),
      .btn                 (btn.src)
   );

   // ---- Timebase state
   logic [31:0] tdiv_reg, tdiv_next, sdiv_reg, sdiv_next;
   logic [31:0] sec_reg, sec_next;
   logic        tick_reg, tick_next, hold_reg, hold_next;
   // ---- Sequencer state
   tsp_state_e  st_reg, st_next;
   logic [3:0]  tcnt_reg, tcnt_next;
   logic [31:0] pw_reg, pw_next;
   logic        en_reg, en_next;
   logic [1:0]  par_reg, par_next;
   // ---- Tamper state
   logic        lat_reg, lat_next, sym_reg, sym_next, led_reg, led_next;
   logic [31:0] stamp_reg, stamp_next;
   logic        tam_set;
   // ---- Supply state
   logic        sel_reg, sel_next, mok_reg, evt_reg, evt_next;
   logic        ind_reg, ind_next, main_ok, bk_ok, sys_low;
   // ---- Register state
   logic        auto_reg, auto_next;
   logic [15:0] hoff_reg, hoff_next;
   logic [2:0]  sv_reg, sv_next, bk_reg, bk_next, mn_reg, mn_next;
   logic [31:0] rd_reg, rd_next;
   logic        mapped, wr_acc;

   // Tick divider, seconds counter and holdoff flag
   always_comb begin
      tdiv_next = tdiv_reg + 32'h0000_0001;
      tick_next = 1'b0;
      if (tdiv_reg == 32'(TICK_CNT - 1)) begin
         tdiv_next = 32'h0000_0000;
         tick_next = 1'b1;
      end
      sdiv_next = sdiv_reg + 32'h0000_0001;
      sec_next  = sec_reg;
      if (sdiv_reg == 32'(SEC_CNT - 1)) begin
         sdiv_next = 32'h0000_0000;
         sec_next  = sec_reg + 32'h0000_0001;
      end
      hold_next = hold_reg | (sec_reg >= {16'h0000, hoff_reg});
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdiv_reg <= 32'h0000_0000;
         sdiv_reg <= 32'h0000_0000;
         sec_reg  <= 32'h0000_0000;
         tick_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else begin
         tdiv_reg <= tdiv_next;
         sdiv_reg <= sdiv_next;
         sec_reg  <= sec_next;
         tick_reg <= tick_next;
         hold_reg <= hold_next;
      end
   end

   // Tick counting, enable pulse and sampling sequence
   always_comb begin
      st_next   = st_reg;
      tcnt_next = tcnt_reg;
      pw_next   = pw_reg;
      en_next   = en_reg;
      par_next  = par_reg;
      if (tick_reg) begin
         tcnt_next = tcnt_reg + 4'h1;
         if (tcnt_next == TICK_FULL) begin
            tcnt_next = 4'h0;
            par_next  = par_reg + 2'h1;
         end
      end
      unique case (st_reg)
         ST_IDLE: begin
            if (tick_reg && (tcnt_reg + 4'h1 == TICK_HALF ||
                             tcnt_reg + 4'h1 == TICK_FULL)) begin
               st_next = ST_PULSE;
               en_next = 1'b1;
               pw_next = 32'h0000_0000;
            end
         end
         ST_PULSE: begin
            pw_next = pw_reg + 32'h0000_0001;
            if (pw_reg == 32'(PW_TERM - 1)) begin
               st_next = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            en_next = 1'b0;
            st_next = ST_IDLE;
            pw_next = 32'h0000_0000;
         end
         default: begin
            st_next = ST_IDLE;
            en_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg   <= ST_IDLE;
         tcnt_reg <= 4'h0;
         pw_reg   <= 32'h0000_0000;
         en_reg   <= 1'b0;
         par_reg  <= 2'h0;
      end else begin
         st_reg   <= st_next;
         tcnt_reg <= tcnt_next;
         pw_reg   <= pw_next;
         en_reg   <= en_next;
         par_reg  <= par_next;
      end
   end

   // Tamper latch, timestamp and indicators; a new event beats a clear
   assign tam_set = (st_reg == ST_SAMPLE) && hold_reg &&
                    tamper_capture_input && !lat_reg;
   always_comb begin
      lat_next   = lat_reg;
      stamp_next = stamp_reg;
      sym_next   = sym_reg;
      led_next   = led_reg;
      if (btn.press && !sel_reg) begin
         lat_next   = 1'b0;
         stamp_next = 32'h0000_0000;
      end
      if (tam_set) begin
         lat_next   = 1'b1;
         stamp_next = sec_reg;
      end
      if (st_reg == ST_SAMPLE) begin
         sym_next = lat_next;
         if (!sel_reg) begin
            led_next = lat_next;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_reg   <= 1'b0;
         stamp_reg <= 32'h0000_0000;
         sym_reg   <= 1'b0;
         led_reg   <= 1'b0;
      end else begin
         lat_reg   <= lat_next;
         stamp_reg <= stamp_next;
         sym_reg   <= sym_next;
         led_reg   <= led_next;
      end
   end

   // Supply selection between main and backup
   assign main_ok = at_least(main_supply, mn_reg);
   assign bk_ok   = at_least(backup_supply, bk_reg);
   assign sys_low = !at_least(system_supply, sv_reg);
   always_comb begin
      sel_next = sel_reg;
      ind_next = ind_reg;
      if (auto_reg) begin
         if (sel_reg && main_ok && !mok_reg) begin
            sel_next = 1'b0;
         end else if (sys_low && !sel_reg && bk_ok) begin
            sel_next = 1'b1;
         end else if (sys_low && sel_reg && main_ok) begin
            sel_next = 1'b0;
         end
      end
      evt_next = sel_next != sel_reg;
      if (tick_reg) begin
         ind_next = sel_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= 1'b0;
         mok_reg <= 1'b0;
         evt_reg <= 1'b0;
         ind_reg <= 1'b0;
      end else begin
         sel_reg <= sel_next;
         mok_reg <= main_ok;
         evt_reg <= evt_next;
         ind_reg <= ind_next;
      end
   end

   // APB slave: no wait states, error on unmapped offsets
   assign mapped = hit(paddr, OFS_CTRL) || hit(paddr, OFS_HOLDOFF) ||
                   hit(paddr, OFS_LEVELS) || hit(paddr, OFS_STATUS) ||
                   hit(paddr, OFS_STAMP) || hit(paddr, OFS_SECONDS);
   assign wr_acc = psel && penable && pwrite && mapped;
   always_comb begin
      auto_next = auto_reg;
      hoff_next = hoff_reg;
      sv_next   = sv_reg;
      bk_next   = bk_reg;
      mn_next   = mn_reg;
      rd_next   = rd_reg;
      if (wr_acc && hit(paddr, OFS_CTRL)) begin
         auto_next = pwdata[CTRL_AUTO_BIT];
      end
      if (wr_acc && hit(paddr, OFS_HOLDOFF)) begin
         hoff_next = pwdata[15:0];
      end
      if (wr_acc && hit(paddr, OFS_LEVELS)) begin
         sv_next = pwdata[LVL_SV_LSB +: 3];
         bk_next = pwdata[LVL_BK_LSB +: 3];
         mn_next = pwdata[LVL_MN_LSB +: 3];
      end
      // Read data is loaded in the setup cycle
      if (psel && !penable) begin
         rd_next = 32'h0000_0000;
         if (hit(paddr, OFS_CTRL)) begin
            rd_next[CTRL_AUTO_BIT] = auto_reg;
         end else if (hit(paddr, OFS_HOLDOFF)) begin
            rd_next[15:0] = hoff_reg;
         end else if (hit(paddr, OFS_LEVELS)) begin
            rd_next[LVL_SV_LSB +: 3] = sv_reg;
            rd_next[LVL_BK_LSB +: 3] = bk_reg;
            rd_next[LVL_MN_LSB +: 3] = mn_reg;
         end else if (hit(paddr, OFS_STATUS)) begin
            rd_next[7:0] = {2'h0, lat_reg, hold_reg, sel_reg,
                            en_reg, par_reg};
            rd_next[11:8] = tcnt_reg;
         end else if (hit(paddr, OFS_STAMP)) begin
            rd_next = stamp_reg;
         end else if (hit(paddr, OFS_SECONDS)) begin
            rd_next = sec_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_reg <= CTRL_AUTO_RST;
         hoff_reg <= HOLDOFF_RST;
         sv_reg   <= SV_LVL_RST;
         bk_reg   <= BK_OK_RST;
         mn_reg   <= MN_OK_RST;
         rd_reg   <= 32'h0000_0000;
      end else begin
         auto_reg <= auto_next;
         hoff_reg <= hoff_next;
         sv_reg   <= sv_next;
         bk_reg   <= bk_next;
         mn_reg   <= mn_next;
         rd_reg   <= rd_next;
      end
   end

   // Outputs
   assign prdata                   = rd_reg;
   assign pready                   = 1'b1;
   assign pslverr                  = psel && penable && !mapped;
   assign sensor_enable            = en_reg;
   assign tamper_symbol            = sym_reg;
   assign tamper_led               = led_reg;
   assign supply_indicator         = ind_reg;
   assign supply_on_backup         = sel_reg;
   assign second_aux_supply_enable = 1'b0;
   assign supply_switch_event      = evt_reg;
   assign display_param            = par_reg;

   // Helper: length of the current enable pulse
   logic [31:0] len_reg, len_next;
   always_comb begin
      len_next = en_reg ? len_reg + 32'h0000_0001 : 32'h0000_0000;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_reg <= 32'h0000_0000;
      end else begin
         len_reg <= len_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_trigger;
      tick_reg && st_reg == ST_IDLE &&
         (tcnt_reg == 4'h3 || tcnt_reg == 4'h7);
   endsequence
   sequence seq_sample_off;
      st_reg == ST_SAMPLE ##1 (!en_reg && st_reg == ST_IDLE);
   endsequence

   AST_EN_WIDTH: assert property ($fell(en_reg) |->
      len_reg == 32'(PW_CNT))
      else $error("Enable pulse width wrong");
   AST_TRIGGER: assert property (seq_trigger |=>
      en_reg && st_reg == ST_PULSE && pw_reg == 32'h0000_0000)
      else $error("Trigger did not start pulse");
   AST_ONE_END: assert property ($rose(en_reg) |->
      !(st_reg == ST_SAMPLE) until_with (st_reg == ST_PULSE &&
      pw_reg == 32'(PW_TERM - 1)))
      else $error("Early pulse end");
   AST_WRAP: assert property (tick_reg && tcnt_reg == 4'h7 |=>
      tcnt_reg == 4'h0 && par_reg == $past(par_reg) + 2'h1)
      else $error("Two-second wrap wrong");
   AST_END_SEQ: assert property (st_reg == ST_PULSE &&
      pw_reg == 32'(PW_TERM - 1) |=> seq_sample_off)
      else $error("Sample then disable order wrong");
   AST_HOLDOFF: assert property (!hold_reg |=> !$rose(lat_reg))
      else $error("Tamper taken before holdoff");
   AST_STAMP: assert property ($rose(lat_reg) |->
      stamp_reg == $past(sec_reg))
      else $error("Timestamp not captured");
   AST_LED: assert property (st_reg == ST_SAMPLE && sel_reg |=>
      $stable(led_reg))
      else $error("LED updated on backup");
   AST_SWITCH_EVT: assert property ($changed(sel_reg) |->
      evt_reg)
      else $error("Supply change without event");
   AST_RETURN: assert property (auto_reg && sel_reg && main_ok &&
      !mok_reg |=> !sel_reg)
      else $error("No return to main supply");
   AST_TICK: assert property (tick_reg |=> !tick_reg [*4])
      else $error("Ticks too close");
endmodule // tsp_poll_sequencer

// *** tb/tsp_sensor_model.sv ***
// Behavioural inductive switch sensor answering the enable pulse
`timescale 1ns/1ps
module tsp_sensor_model #(
   parameter int unsigned CONV_CYC = 3
) (
   input  wire logic pclk,
   input  wire logic sensor_enable,
   input  wire logic tamper_present,
   output logic      sensor_out
);
   int unsigned on_cnt = 0;
   initial sensor_out = 1'b0;
   // Output is valid only after a conversion, else it toggles each cycle
   always @(posedge pclk) begin
      if (sensor_enable) begin
         on_cnt <= on_cnt + 1;
      end else begin
         on_cnt <= 0;
      end
      if (sensor_enable && on_cnt >= CONV_CYC) begin
         sensor_out <= tamper_present;
      end else begin
         sensor_out <= ~sensor_out;
      end
   end
endmodule // tsp_sensor_model

// *** tb/testbench.sv ***
// Self-checking bench for the tamper poll sequencer
`timescale 1ns/1ps
module testbench;
   import tsp_pkg::*;
   localparam int unsigned TK = 200;
   localparam int unsigned SC = 100;
   localparam int unsigned PW = 10;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sens_out;
   logic        tamper_on = 1'b1;
   logic        button = 1'b0;
   logic [2:0]  main_lvl = 3'h7;
   logic [2:0]  back_lvl = 3'h7;
   logic [2:0]  sys_lvl = 3'h7;
   logic        en;
   logic        sym;
   logic        led;
   logic        ind;
   logic        on_bk;
   logic        aux2;
   logic        evt;
   logic [1:0]  dparam;
   int unsigned cyc = 0;
   int unsigned n_errors = 0;
   int unsigned samples_checked = 0;
   int unsigned w;
   int unsigned t1;
   int unsigned t2;
   tsp_poll_sequencer #(.TICK_CNT(TK), .SEC_CNT(SC), .PW1_CNT(PW),
      .PW2_CNT(14), .DB_CNT(4)) tsp_poll_sequencer_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tamper_capture_input(sens_out),
      .tamper_clear_button(button), .main_supply(main_lvl),
      .backup_supply(back_lvl), .system_supply(sys_lvl),
      .sensor_enable(en), .tamper_symbol(sym), .tamper_led(led),
      .supply_indicator(ind), .supply_on_backup(on_bk),
      .second_aux_supply_enable(aux2), .supply_switch_event(evt),
      .display_param(dparam));
   tsp_sensor_model tsp_sensor_model_i (.pclk(pclk), .sensor_enable(en),
      .tamper_present(tamper_on), .sensor_out(sens_out));
   // Clock and cycle count since reset release
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) if (presetn) cyc <= cyc + 1;
   task final_report;
      if (n_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] r, output logic er);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!(pready === 1'b1) && n < 50);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         final_report();
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] r;
      logic        er;
      apb(1'b0, a, 32'h0000_0000, r, er);
      chk(r & m, e);
      chk({31'h0, er}, {31'h0, a > OFS_SECONDS});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, d, r, er);
   endtask
   // Waits for one enable pulse; returns its width and end cycle
   task pulse(output int unsigned pw, output int unsigned t);
      int n;
      n = 0;
      pw = 0;
      while (en !== 1'b1 && n < 4 * TK + 50) begin
         @(posedge pclk);
         n++;
      end
      while (en === 1'b1 && pw < 4 * PW) begin
         @(posedge pclk);
         pw++;
      end
      t = cyc;
      if (n >= 4 * TK + 50 || pw >= 4 * PW) begin
         n_errors++;
         final_report();
      end
   endtask
   task press;
      button <= 1'b1;
      repeat (12) @(posedge pclk);
      button <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   task wait_evt;
      int n;
      n = 0;
      while (evt !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
      chk({31'h0, evt}, 32'h0000_0000);
      if (n >= 20) begin
         n_errors++;
         final_report();
      end
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
      rd(OFS_HOLDOFF, 32'h0000_000A, 32'hFFFF_FFFF);
      rd(OFS_LEVELS, 32'h0000_0655, 32'hFFFF_FFFF);
      rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF);
      wr(OFS_HOLDOFF, 32'h0000_000C);
      rd(OFS_HOLDOFF, 32'h0000_000C, 32'hFFFF_FFFF);
      chk({31'h0, aux2}, 32'h0000_0000);
      pulse(w, t1);
      chk(32'(w), 32'(PW));
      rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0023);
      pulse(w, t2);
      chk(32'(t2 - t1), 32'(4 * TK));
      rd(OFS_STATUS, 32'h0000_0021, 32'h0000_0023);
      rd(OFS_STAMP, 32'(t2 / SC), 32'hFFFF_FFFF);
      chk({30'h0, sym, led}, 32'h0000_0003);
      tamper_on <= 1'b0;
      pulse(w, t1);
      chk({30'h0, sym, led}, 32'h0000_0003);
      rd(OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
      press();
      rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0020);
      rd(OFS_STAMP, 32'h0000_0000, 32'hFFFF_FFFF);
      // A clean sample on main supply brings symbol and LED back down
      pulse(w, t1);
      chk({30'h0, sym, led}, 32'h0000_0000);
      main_lvl <= 3'h3;
      sys_lvl <= 3'h2;
      wait_evt();
      chk({31'h0, on_bk}, 32'h0000_0001);
      repeat (TK + 4) @(posedge pclk);
      chk({31'h0, ind}, 32'h0000_0001);
      tamper_on <= 1'b1;
      pulse(w, t1);
      chk({30'h0, sym, led}, 32'h0000_0002);
      press();
      rd(OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
      sys_lvl <= 3'h7;
      main_lvl <= 3'h7;
      wait_evt();
      chk({31'h0, on_bk}, 32'h0000_0000);
      repeat (TK + 4) @(posedge pclk);
      chk({31'h0, ind}, 32'h0000_0000);
      tamper_on <= 1'b0;
      press();
      rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0020);
      final_report();
   end
endmodule // testbench
